// ===== include/qdac_defines.vh
// Constants for the quad DAC serial command decoder
//
// Summary of operation
// R1: Control 01 loads the addressed input register only; DAC registers stay.
// R2: Control 11 loads the addressed input register and its DAC register.
// R3: Control 11 also moves all other input registers into DAC registers.
// R4: Address 00..11 selects channel A, B, C, D.
// R5: Code 0100 copies all input registers to DAC registers, ends shutdown.
// R6: Code 1000 writes data to all DAC registers and ends shutdown.
// R7: Code 1100 enters shutdown only while power-down-allow is high.
// R8: Code 0010 drives user output low, 0110 high; level is held.
// R9: Code 0000 changes no register; word only passes the shift register.
// R10: Code 1110 makes serial output change on rising edge, updates all DACs.
// R11: Serial output phase stays latched until reset or falling-phase command.
// R12: Code 1010 makes serial output change on falling edge, updates all DACs.
// R13: Commands without data ignore the eight data bits.
// R14: Master loads three channels with 01 then last with 11.
// R15: Word is MSB first, sampled on serial rising edges, run on select rise.
// R16: Load strobe low makes DAC registers follow input registers.
// R17: Clear low resets all input and DAC registers to zero.
// R18: Reset zeroes interface and registers and selects falling output phase.
// R19: Only software load and broadcast load end shutdown.
`ifndef QDAC_DEFINES_VH
`define QDAC_DEFINES_VH
`define QDAC_WORD_W 12
`define QDAC_CODE_LD_ALL 4'h4
`define QDAC_CODE_BCAST 4'h8
`define QDAC_CODE_SHDN 4'hC
`define QDAC_CODE_UPO_LO 4'h2
`define QDAC_CODE_UPO_HI 4'h6
`define QDAC_CODE_NOP 4'h0
`define QDAC_CODE_PH_RISE 4'hE
`define QDAC_CODE_PH_FALL 4'hA
`define QDAC_CTL_LOAD_IN 2'h1
`define QDAC_CTL_LOAD_UPD 2'h3
`endif

// ===== logic/qdac_decoder.v
// Serial command decoder for a quad 8-bit DAC
`timescale 1ns/10ps
`include "qdac_defines.vh"
module qdac_decoder
(
   // Clock and reset
   input wire clk,
   input wire srst,
   // Serial link pins
   input wire sclk,
   input wire cs_n,
   input wire din,
   output reg dout,
   // Control pins
   input wire load_strobe_n,
   input wire clear_n,
   input wire power_down_allow,
   // Outputs
   output reg user_logic_out,
   output reg shutdown,
   output reg dout_rising_mode,
   output reg [7:0] dac_a,
   output reg [7:0] dac_b,
   output reg [7:0] dac_c,
   output reg [7:0] dac_d
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   reg [2:0] sclk_s_r;
   reg [2:0] cs_s_r;
   reg [2:0] din_s_r;
   reg [2:0] ld_s_r;
   reg [2:0] clr_s_r;
   reg [2:0] pde_s_r;
   reg sclk_r;
   reg cs_r;
   reg din_r;
   reg ld_r;
   reg clr_r;
   reg pde_r;
   reg [11:0] shift_r;
   reg [7:0] in_a_r;
   reg [7:0] in_b_r;
   reg [7:0] in_c_r;
   reg [7:0] in_d_r;
   reg [7:0] in_a_nxt;
   reg [7:0] in_b_nxt;
   reg [7:0] in_c_nxt;
   reg [7:0] in_d_nxt;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_rise;
   wire [1:0] addr;
   wire [1:0] ctl;
   wire [3:0] code;
   wire [7:0] data;
   reg upd_all;
   reg bcast;

   // Three stages; a change counts when stages two and three agree
   always @(posedge clk)
   begin
      if (srst)
      begin
         sclk_s_r <= 3'h0;
         cs_s_r <= 3'h7;
         din_s_r <= 3'h0;
         ld_s_r <= 3'h7;
         clr_s_r <= 3'h7;
         pde_s_r <= 3'h0;
         sclk_r <= 1'b0;
         cs_r <= 1'b1;
         din_r <= 1'b0;
         ld_r <= 1'b1;
         clr_r <= 1'b1;
         pde_r <= 1'b0;
      end
      else
      begin
         sclk_s_r <= {sclk_s_r[1:0], sclk};
         cs_s_r <= {cs_s_r[1:0], cs_n};
         din_s_r <= {din_s_r[1:0], din};
         ld_s_r <= {ld_s_r[1:0], load_strobe_n};
         clr_s_r <= {clr_s_r[1:0], clear_n};
         pde_s_r <= {pde_s_r[1:0], power_down_allow};
         if (sclk_s_r[1] == sclk_s_r[2]) sclk_r <= sclk_s_r[2];
         if (cs_s_r[1] == cs_s_r[2]) cs_r <= cs_s_r[2];
         if (din_s_r[1] == din_s_r[2]) din_r <= din_s_r[2];
         if (ld_s_r[1] == ld_s_r[2]) ld_r <= ld_s_r[2];
         if (clr_s_r[1] == clr_s_r[2]) clr_r <= clr_s_r[2];
         if (pde_s_r[1] == pde_s_r[2]) pde_r <= pde_s_r[2];
      end
   end

   // Edge detection on filtered levels
   assign sclk_rise = (sclk_s_r[1] == sclk_s_r[2]) & sclk_s_r[2] & ~sclk_r;
   assign sclk_fall = (sclk_s_r[1] == sclk_s_r[2]) & ~sclk_s_r[2] & sclk_r;
   assign cs_rise = (cs_s_r[1] == cs_s_r[2]) & cs_s_r[2] & ~cs_r;

   // ****************************************
   // Shift register and serial output
   // ****************************************
   always @(posedge clk)
   begin
      if (srst)
      begin
         shift_r <= 12'h000; // R18
         dout <= 1'b0;
      end
      else
      begin
         if (sclk_rise && !cs_r)
            shift_r <= {shift_r[10:0], din_r}; // R15
         // Output follows the word's top bit on the selected edge
         if (!cs_r && ((dout_rising_mode && sclk_rise) || (!dout_rising_mode && sclk_fall)))
            dout <= shift_r[11];
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   assign addr = shift_r[11:10];
   assign ctl = shift_r[9:8];
   assign code = shift_r[11:8];
   assign data = shift_r[7:0]; // R13

   // Next input registers and update flags
   always @*
   begin
      in_a_nxt = in_a_r;
      in_b_nxt = in_b_r;
      in_c_nxt = in_c_r;
      in_d_nxt = in_d_r;
      upd_all = 1'b0;
      bcast = 1'b0;
      if (cs_rise)
      begin
         if (ctl == `QDAC_CTL_LOAD_IN || ctl == `QDAC_CTL_LOAD_UPD) // R1 R2
         begin
            case (addr) // R4
               2'h0: in_a_nxt = data;
               2'h1: in_b_nxt = data;
               2'h2: in_c_nxt = data;
               default: in_d_nxt = data;
            endcase
            upd_all = (ctl == `QDAC_CTL_LOAD_UPD); // R3
         end
         else
         begin
            case (code)
               `QDAC_CODE_LD_ALL: upd_all = 1'b1; // R5
               `QDAC_CODE_PH_RISE: upd_all = 1'b1; // R10
               `QDAC_CODE_PH_FALL: upd_all = 1'b1; // R12
               `QDAC_CODE_BCAST: bcast = 1'b1; // R6
               default: upd_all = 1'b0; // R9
            endcase
         end
      end
   end

   // ****************************************
   // Input and DAC registers
   // ****************************************
   always @(posedge clk)
   begin
      if (srst || !clr_r)
      begin
         in_a_r <= 8'h00; // R17 R18
         in_b_r <= 8'h00;
         in_c_r <= 8'h00;
         in_d_r <= 8'h00;
         dac_a <= 8'h00;
         dac_b <= 8'h00;
         dac_c <= 8'h00;
         dac_d <= 8'h00;
      end
      else
      begin
         in_a_r <= in_a_nxt;
         in_b_r <= in_b_nxt;
         in_c_r <= in_c_nxt;
         in_d_r <= in_d_nxt;
         if (bcast)
         begin
            dac_a <= data; // R6
            dac_b <= data;
            dac_c <= data;
            dac_d <= data;
         end
         else if (upd_all || !ld_r)
         begin
            dac_a <= in_a_nxt; // R16
            dac_b <= in_b_nxt;
            dac_c <= in_c_nxt;
            dac_d <= in_d_nxt;
         end
      end
   end

   // ****************************************
   // Mode state: shutdown, user output, phase
   // ****************************************
   always @(posedge clk)
   begin
      if (srst)
      begin
         shutdown <= 1'b0;
         user_logic_out <= 1'b0;
         dout_rising_mode <= 1'b0; // R18
      end
      else if (cs_rise)
      begin
         case (code)
            `QDAC_CODE_LD_ALL: shutdown <= 1'b0; // R19
            `QDAC_CODE_BCAST: shutdown <= 1'b0; // R19
            `QDAC_CODE_SHDN: if (pde_r) shutdown <= 1'b1; // R7
            `QDAC_CODE_UPO_LO: user_logic_out <= 1'b0; // R8
            `QDAC_CODE_UPO_HI: user_logic_out <= 1'b1; // R8
            `QDAC_CODE_PH_RISE: dout_rising_mode <= 1'b1; // R10
            `QDAC_CODE_PH_FALL: dout_rising_mode <= 1'b0; // R11 R12
            default: shutdown <= shutdown;
         endcase
      end
   end

endmodule

// ===== bench/qdac_master.sv
// Serial master model driving the decoder's link pins
`timescale 1ns/10ps
module qdac_master
(
   // Link pins
   output logic sclk,
   output logic cs_n,
   output logic din,
   input logic dout,
   // Serial output as read on each clock edge
   output logic [11:0] rx_rise,
   output logic [11:0] rx_fall
);
   // Idle: clock low, not selected
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      rx_rise = 12'h000;
      rx_fall = 12'h000;
   end
   // Shift one word MSB first, then execute with select rising
   task send(input logic [11:0] w);
      integer i;
      cs_n = 1'b0;
      #32;
      for (i = 11; i >= 0; i--)
      begin
         din = w[i];
         #32;
         // Falling phase output is read on rising edges, rising phase on falling edges
         rx_rise = {rx_rise[10:0], dout};
         sclk = 1'b1;
         #32;
         rx_fall = {rx_fall[10:0], dout};
         sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      din = ~din; // Released line shows no stale bit
      #64;
   endtask
endmodule

// ===== bench/qdac_checker.sv
// Port checker for the quad DAC command decoder
`timescale 1ns/10ps
module qdac_checker
(
   // Clock, reset and pins
   input logic clk,
   input logic srst,
   input logic cs_n,
   input logic load_strobe_n,
   input logic clear_n,
   input logic power_down_allow,
   // Outputs
   input logic dout,
   input logic user_logic_out,
   input logic shutdown,
   input logic dout_rising_mode,
   input logic [7:0] dac_a,
   input logic [7:0] dac_b,
   input logic [7:0] dac_c,
   input logic [7:0] dac_d
);
   logic [3:0] since_r;
   wire [31:0] dacs = {dac_a, dac_b, dac_c, dac_d};
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Cycles since select returned high, saturating
   always @(posedge clk)
   begin
      if (srst || !cs_n)
         since_r <= 4'h0;
      else if (since_r != 4'hF)
         since_r <= since_r + 4'h1;
   end
   sequence s_clr_held; (!clear_n)[*8]; endsequence
   sequence s_idle_hi; cs_n[*8]; endsequence
   AST_RST: assert property ($fell(srst) |-> dacs == 32'h0 && !shutdown && !user_logic_out && !dout_rising_mode)
      else $error("outputs not cleared by reset");
   AST_CLR: assert property (s_clr_held |-> dacs == 32'h0)
      else $error("clear did not zero the DACs");
   AST_SHDN_PDE: assert property ($rose(shutdown) |-> power_down_allow)
      else $error("shutdown entered while not allowed");
   AST_DOUT_HOLD: assert property (s_idle_hi |=> $stable(dout))
      else $error("serial output moved while deselected");
   AST_UPO_CMD: assert property ($changed(user_logic_out) |-> since_r < 4'hA)
      else $error("user output changed without a command");
   AST_MODE_CMD: assert property ($changed(dout_rising_mode) |-> since_r < 4'hA)
      else $error("output phase changed without a command");
   AST_SHDN_CMD: assert property ($changed(shutdown) |-> since_r < 4'hA)
      else $error("shutdown changed without a command");
   AST_DAC_CMD: assert property ($changed(dacs) && load_strobe_n && clear_n
      && $past(load_strobe_n && clear_n, 8) |-> since_r < 4'hA)
      else $error("DAC changed without a command");
endmodule

// ===== bench/qdac_decoder_test.sv
// Self-checking bench for the quad DAC command decoder
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module qdac_decoder_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic load_strobe_n = 1'b1;
   logic clear_n = 1'b1;
   logic power_down_allow = 1'b0;
   wire sclk, cs_n, din, dout, user_logic_out, shutdown, dout_rising_mode;
   wire [7:0] dac_a, dac_b, dac_c, dac_d;
   wire [31:0] dacs = {dac_a, dac_b, dac_c, dac_d};
   wire [11:0] rx_rise, rx_fall;
   int err_total = 0;
   int checks_done = 0;
   always #2 clk = ~clk;
   qdac_master u_m (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .rx_rise(rx_rise), .rx_fall(rx_fall));
   qdac_decoder dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .load_strobe_n(load_strobe_n), .clear_n(clear_n), .power_down_allow(power_down_allow),
      .user_logic_out(user_logic_out), .shutdown(shutdown), .dout_rising_mode(dout_rising_mode),
      .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_d(dac_d));
   // Send one command word and let it settle
   task cmd(input logic [3:0] code, input logic [7:0] data);
      u_m.send({code, data});
      repeat (10) @(negedge clk);
   endtask
   task t_reset;
      `CHK("rst", 36'h0, {shutdown, user_logic_out, dout_rising_mode, dout, dacs})
   endtask
   task t_load;
      int ch;
      for (ch = 0; ch < 3; ch++)
         cmd({ch[1:0], 2'b01}, 8'h10 + ch[7:0]);
      `CHK("held", 32'h0, dacs)
      cmd(4'hF, 8'hD3);
      `CHK("upd", 32'h101112D3, dacs)
   endtask
   task t_shdn;
      cmd(4'hC, 8'h00);
      `CHK("shdn off", 1'b0, shutdown)
      power_down_allow = 1'b1;
      cmd(4'hC, 8'h00);
      `CHK("shdn on", 1'b1, shutdown)
      cmd(4'h6, 8'h00);
      `CHK("shdn kept", 1'b1, shutdown)
      cmd(4'h1, 8'h77);
      cmd(4'h4, 8'hFF);
      `CHK("swload", 33'h0771112D3, {shutdown, dacs})
      cmd(4'hC, 8'h00);
      cmd(4'h8, 8'h00);
      `CHK("bcast", 33'h0, {shutdown, dacs})
   endtask
   task t_upo;
      cmd(4'h0, 8'hFF);
      `CHK("nop", 33'h100000000, {user_logic_out, dacs})
      cmd(4'h2, 8'hFF);
      `CHK("echo0", 12'h0FF, rx_rise)
      `CHK("upo lo", 1'b0, user_logic_out)
      cmd(4'h6, 8'h00);
      `CHK("upo hi", 1'b1, user_logic_out)
   endtask
   task t_phase;
      cmd(4'hC, 8'h00);
      cmd(4'hE, 8'h5A);
      `CHK("rise", 34'h3771112D3, {shutdown, dout_rising_mode, dacs})
      cmd(4'h8, 8'h21);
      `CHK("echo1", 12'hE5A, rx_fall)
      `CHK("kept", 2'h2, {dout_rising_mode, shutdown})
      cmd(4'hA, 8'h00);
      `CHK("fall", 33'h0771112D3, {dout_rising_mode, dacs})
   endtask
   task t_hw;
      cmd(4'h5, 8'h3C);
      load_strobe_n = 1'b0;
      repeat (20) @(negedge clk);
      `CHK("load_strobe_n", 32'h773C12D3, dacs)
      load_strobe_n = 1'b1;
      clear_n = 1'b0;
      repeat (12) @(negedge clk);
      clear_n = 1'b1;
      cmd(4'h4, 8'h00);
      `CHK("clear", 32'h0, dacs)
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset;
      t_load;
      t_shdn;
      t_upo;
      t_phase;
      t_hw;
      final_report;
   end
   // Watchdog
   initial
   begin
      #100000;
      err_total++;
      final_report;
   end
endmodule
bind qdac_decoder qdac_checker u_chk (.clk(clk), .srst(srst), .cs_n(cs_n), .load_strobe_n(load_strobe_n),
   .clear_n(clear_n), .power_down_allow(power_down_allow), .dout(dout), .user_logic_out(user_logic_out),
   .shutdown(shutdown), .dout_rising_mode(dout_rising_mode), .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c),
   .dac_d(dac_d));
